// ===== design/adc_cfg_map.vh
// Offsets, field positions, reset values and timing codes of the config slice
`ifndef ADC_CFG_MAP_VH
`define ADC_CFG_MAP_VH

`define ADDR_W 8
`define DATA_W 8

`define OFS_AMP_DELAY 8'h03
`define OFS_RATE_CFG 8'h04
`define OFS_REF_CTRL 8'h05

`define RST_AMP_DELAY 8'h00
`define RST_RATE_CFG 8'h14
`define RST_REF_CTRL 8'h10
`define RDATA_UNMAPPED 8'h00

// Amplifier and delay register fields
`define DELAY_MSB 7
`define DELAY_LSB 5
`define AMPEN_MSB 4
`define AMPEN_LSB 3
`define GAIN_MSB 2
`define GAIN_LSB 0

// Rate register fields
`define CHOP_BIT 7
`define CLKSRC_BIT 6
`define MODE_BIT 5
`define FILTER_BIT 4
`define RATE_MSB 3
`define RATE_LSB 0

// Reference control fields
`define MON_MSB 7
`define MON_LSB 6
`define PBUF_BIT 5
`define NBUF_BIT 4
`define REFSEL_MSB 3
`define REFSEL_LSB 2
`define REFCFG_MSB 1
`define REFCFG_LSB 0

// Amplifier enable codes
`define AMPEN_BYPASS 2'h0
`define AMPEN_ON 2'h1

// Reference source and internal reference codes
`define REFSEL_EXT0 2'h0
`define REFSEL_EXT1 2'h1
`define REFSEL_INT 2'h2
`define REFCFG_OFF 2'h0
`define REFCFG_PDOWN 2'h1
`define REFCFG_ALWAYS 2'h2

// Conversion delay in modulator periods, per delay code
`define DLY_W 12
`define DLY_CODE0 12'h00E
`define DLY_CODE1 12'h019
`define DLY_CODE2 12'h040
`define DLY_CODE3 12'h100
`define DLY_CODE4 12'h400
`define DLY_CODE5 12'h800
`define DLY_CODE6 12'h800
`define DLY_CODE7 12'h001

// Output rate in hundredths of samples per second
`define RATE_VAL_W 17
`define RATE_C0 17'h000FA
`define RATE_C1 17'h001F4
`define RATE_C2 17'h003E8
`define RATE_C3 17'h0067C
`define RATE_C4 17'h007D0
`define RATE_C5 17'h01388
`define RATE_C6 17'h01770
`define RATE_C7 17'h02710
`define RATE_C8 17'h04E20
`define RATE_C9 17'h09C40
`define RATE_C10 17'h13880
`define RATE_C11 17'h186A0
`define RATE_NONE 17'h00000

// Internal oscillator rate in kHz
`define INT_OSC_KHZ 16'h1000

`endif

// ===== design/conv_delay_timer.v
// Counts the first-conversion delay in modulator periods
`include "adc_cfg_map.vh"

module conv_delay_timer #(
  parameter CNT_W = `DLY_W
) (
  input wire clk_in,
  input wire nrst_in,
  input wire load_in,
  input wire [CNT_W-1:0] periods_in,
  input wire mod_tick_in,
  output wire busy_out,
  output reg done_out
);

  reg [CNT_W-1:0] cnt_r;
  reg busy_r;

  assign busy_out = busy_r;

  // A fresh load restarts the wait, so back-to-back changes never stack
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= {CNT_W{1'b0}};
      busy_r <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (load_in) begin
        cnt_r <= periods_in;
        busy_r <= 1'b1;
      end else if (busy_r && mod_tick_in) begin
        if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy_r <= 1'b0;
          done_out <= 1'b1;
        end
        cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // conv_delay_timer

// ===== design/adc_gain_rate_ref_config.v
// Gain, output-rate and reference configuration registers with decoders
`include "adc_cfg_map.vh"

// What this block does
// - Delay codes map to fixed modulator period counts
// - Delay applies only after filter-resetting writes
// - Amplifier code 00 bypasses, 01 enables it
// - Gain equals two to the gain code
// - Bit 7 enables chop, off at reset
// - Bit 6 picks internal or external clock
// - Bit 5 picks continuous or single-shot
// - Bit 4 picks sinc3 or low-latency filter
// - Rate code maps to samples per second
// - Rate register resets to 14h
// - Reference register resets to 10h, fields laid
// - Source select chooses external pairs or internal
// - Internal reference off, power-down or always
module adc_gain_rate_ref_config (
  input wire clk_in,
  input wire nrst_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [`ADDR_W-1:0] addr_in,
  input wire [`DATA_W-1:0] wdata_in,
  input wire mod_tick_in,
  output reg [`DATA_W-1:0] rdata_out,
  output reg amp_enable_out,
  output reg amp_bypass_out,
  output reg amp_reserved_out,
  output reg [7:0] gain_out,
  output reg chop_enable_out,
  output reg ext_clk_sel_out,
  output reg single_shot_out,
  output reg low_latency_filter_out,
  output reg [`RATE_VAL_W-1:0] rate_csps_out,
  output reg rate_reserved_out,
  output reg [1:0] ref_monitor_cfg_out,
  output reg pos_ref_buffer_bypass_out,
  output reg neg_ref_buffer_bypass_out,
  output reg ref_ext0_out,
  output reg ref_ext1_out,
  output reg ref_internal_out,
  output reg int_ref_on_out,
  output reg int_ref_keep_in_pdown_out,
  output reg filter_restart_out,
  output wire delay_busy_out,
  output wire first_conv_start_out
);

  reg [`DATA_W-1:0] amp_delay_r;
  reg [`DATA_W-1:0] rate_cfg_r;
  reg [`DATA_W-1:0] ref_ctrl_r;
  reg [`DLY_W-1:0] delay_periods_r;
  reg [`DLY_W-1:0] delay_periods_nxt;
  reg [`RATE_VAL_W-1:0] rate_nxt;

  wire wr_amp = wr_en_in && (addr_in == `OFS_AMP_DELAY);
  wire wr_rate = wr_en_in && (addr_in == `OFS_RATE_CFG);
  wire wr_ref = wr_en_in && (addr_in == `OFS_REF_CTRL);

  // Only a real change to a filter-shaping register restarts the filter
  wire restart_now = (wr_amp && (wdata_in != amp_delay_r)) ||
                     (wr_rate && (wdata_in != rate_cfg_r));

  wire [2:0] delay_code = amp_delay_r[`DELAY_MSB:`DELAY_LSB];
  wire [1:0] amp_code = amp_delay_r[`AMPEN_MSB:`AMPEN_LSB];
  wire [2:0] gain_code = amp_delay_r[`GAIN_MSB:`GAIN_LSB];
  wire [3:0] rate_code = rate_cfg_r[`RATE_MSB:`RATE_LSB];
  wire [1:0] refsel_code = ref_ctrl_r[`REFSEL_MSB:`REFSEL_LSB];
  wire [1:0] refcfg_code = ref_ctrl_r[`REFCFG_MSB:`REFCFG_LSB];

  // Full bytes stored, so reserved codes read back as written
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      amp_delay_r <= `RST_AMP_DELAY;
      rate_cfg_r <= `RST_RATE_CFG;
      ref_ctrl_r <= `RST_REF_CTRL;
    end else begin
      if (wr_amp) begin
        amp_delay_r <= wdata_in;
      end
      if (wr_rate) begin
        rate_cfg_r <= wdata_in;
      end
      if (wr_ref) begin
        ref_ctrl_r <= wdata_in;
      end
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= `RDATA_UNMAPPED;
    end else if (rd_en_in) begin
      case (addr_in)
        `OFS_AMP_DELAY: rdata_out <= amp_delay_r;
        `OFS_RATE_CFG: rdata_out <= rate_cfg_r;
        `OFS_REF_CTRL: rdata_out <= ref_ctrl_r;
        default: rdata_out <= `RDATA_UNMAPPED;
      endcase
    end
  end

  // Delay taken from the new byte when the amplifier register itself changes
  always @* begin
    delay_periods_nxt = `DLY_CODE0;
    case (wr_amp ? wdata_in[`DELAY_MSB:`DELAY_LSB] : delay_code)
      3'h0: delay_periods_nxt = `DLY_CODE0;
      3'h1: delay_periods_nxt = `DLY_CODE1;
      3'h2: delay_periods_nxt = `DLY_CODE2;
      3'h3: delay_periods_nxt = `DLY_CODE3;
      3'h4: delay_periods_nxt = `DLY_CODE4;
      3'h5: delay_periods_nxt = `DLY_CODE5;
      3'h6: delay_periods_nxt = `DLY_CODE6;
      3'h7: delay_periods_nxt = `DLY_CODE7;
      default: delay_periods_nxt = `DLY_CODE0;
    endcase
  end

  always @* begin
    rate_nxt = `RATE_NONE;
    case (rate_code)
      4'h0: rate_nxt = `RATE_C0;
      4'h1: rate_nxt = `RATE_C1;
      4'h2: rate_nxt = `RATE_C2;
      4'h3: rate_nxt = `RATE_C3;
      4'h4: rate_nxt = `RATE_C4;
      4'h5: rate_nxt = `RATE_C5;
      4'h6: rate_nxt = `RATE_C6;
      4'h7: rate_nxt = `RATE_C7;
      4'h8: rate_nxt = `RATE_C8;
      4'h9: rate_nxt = `RATE_C9;
      4'hA: rate_nxt = `RATE_C10;
      4'hB: rate_nxt = `RATE_C11;
      default: rate_nxt = `RATE_NONE;
    endcase
  end

  // Decoded controls lag the register by one cycle; all are flip-flops
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      amp_enable_out <= 1'h0;
      amp_bypass_out <= 1'h1;
      amp_reserved_out <= 1'h0;
      gain_out <= 8'h01;
    end else begin
      amp_enable_out <= (amp_code == `AMPEN_ON);
      amp_bypass_out <= (amp_code == `AMPEN_BYPASS);
      amp_reserved_out <= amp_code[1];
      // Bypass with a nonzero gain is the host's fault; gain is not forced
      gain_out <= 8'h01 << gain_code;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chop_enable_out <= 1'h0;
      ext_clk_sel_out <= 1'h0;
      single_shot_out <= 1'h0;
      low_latency_filter_out <= 1'h1;
      rate_csps_out <= `RATE_C4;
      rate_reserved_out <= 1'h0;
    end else begin
      chop_enable_out <= rate_cfg_r[`CHOP_BIT];
      ext_clk_sel_out <= rate_cfg_r[`CLKSRC_BIT];
      single_shot_out <= rate_cfg_r[`MODE_BIT];
      low_latency_filter_out <= rate_cfg_r[`FILTER_BIT];
      rate_csps_out <= rate_nxt;
      rate_reserved_out <= (rate_nxt == `RATE_NONE);
    end
  end

  // Reference decode never touches the filter or the delay timer
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_monitor_cfg_out <= 2'h0;
      pos_ref_buffer_bypass_out <= 1'h0;
      neg_ref_buffer_bypass_out <= 1'h1;
      ref_ext0_out <= 1'h1;
      ref_ext1_out <= 1'h0;
      ref_internal_out <= 1'h0;
      int_ref_on_out <= 1'h0;
      int_ref_keep_in_pdown_out <= 1'h0;
    end else begin
      ref_monitor_cfg_out <= ref_ctrl_r[`MON_MSB:`MON_LSB];
      pos_ref_buffer_bypass_out <= ref_ctrl_r[`PBUF_BIT];
      neg_ref_buffer_bypass_out <= ref_ctrl_r[`NBUF_BIT];
      ref_ext0_out <= (refsel_code == `REFSEL_EXT0);
      ref_ext1_out <= (refsel_code == `REFSEL_EXT1);
      ref_internal_out <= (refsel_code == `REFSEL_INT);
      int_ref_on_out <= (refcfg_code == `REFCFG_PDOWN) ||
                        (refcfg_code == `REFCFG_ALWAYS);
      int_ref_keep_in_pdown_out <= (refcfg_code == `REFCFG_ALWAYS);
    end
  end

  // Count latched with the pulse, so the timer loads a settled value
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      filter_restart_out <= 1'h0;
      delay_periods_r <= `DLY_CODE0;
    end else begin
      filter_restart_out <= restart_now;
      if (restart_now) begin
        delay_periods_r <= delay_periods_nxt;
      end
    end
  end

  // Timer loads one cycle after the write, on the edge that ends the restart pulse
  conv_delay_timer #(
    .CNT_W(`DLY_W)
  ) conv_delay_timer_inst (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .load_in(filter_restart_out),
    .periods_in(delay_periods_r),
    .mod_tick_in(mod_tick_in),
    .busy_out(delay_busy_out),
    .done_out(first_conv_start_out)
  );

endmodule // adc_gain_rate_ref_config

// ===== test/adc_cfg_chk.sv
// Port-level assertions for the config slice
module adc_cfg_chk (
  input wire clk_in,
  input wire nrst_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] rdata_out,
  input wire amp_enable_out,
  input wire amp_bypass_out,
  input wire amp_reserved_out,
  input wire [7:0] gain_out,
  input wire chop_enable_out,
  input wire ext_clk_sel_out,
  input wire single_shot_out,
  input wire low_latency_filter_out,
  input wire [16:0] rate_csps_out,
  input wire rate_reserved_out,
  input wire neg_ref_buffer_bypass_out,
  input wire filter_restart_out,
  input wire delay_busy_out,
  input wire first_conv_start_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] wtop = wdata_in[7:4];
  wire wb4 = wdata_in[4];
  wire wr4 = wr_en_in && addr_in == 8'h04;
  wire wr5 = wr_en_in && addr_in == 8'h05;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_restart_busy: assert property (
    filter_restart_out |=> delay_busy_out)
    else $error("busy missing after restart");
  a_ref_quiet: assert property (wr5 |=> !filter_restart_out)
    else $error("restart after reference write");
  a_start_end: assert property (
    first_conv_start_out |-> $past(delay_busy_out))
    else $error("start without delay count");
  a_gain_pow: assert property ($onehot(gain_out))
    else $error("gain not a power of two");
  a_amp_code: assert property ($onehot({
    amp_enable_out, amp_bypass_out, amp_reserved_out}))
    else $error("amplifier flags not exclusive");
  a_rate_none: assert property (
    rate_reserved_out |-> rate_csps_out == 17'h0)
    else $error("reserved rate code gives a rate");
  a_mode_bits: assert property (wr4 |=> ##1
    {chop_enable_out, ext_clk_sel_out, single_shot_out,
    low_latency_filter_out} == $past(wtop, 2))
    else $error("rate mode bits do not follow write");
  a_nbuf_bit: assert property (wr5 |=> ##1
    neg_ref_buffer_bypass_out == $past(wb4, 2))
    else $error("buffer bypass does not follow write");
  a_rd_hold: assert property (!rd_en_in |=> $stable(rdata_out))
    else $error("read data changed without read");
  cover property (first_conv_start_out);
  cover property (delay_busy_out && filter_restart_out);
  cover property (rate_reserved_out);
  cover property (amp_reserved_out);
endmodule // adc_cfg_chk

bind adc_gain_rate_ref_config adc_cfg_chk adc_cfg_chk_inst (.clk_in,
  .nrst_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in, .rdata_out,
  .amp_enable_out, .amp_bypass_out, .amp_reserved_out, .gain_out,
  .chop_enable_out, .ext_clk_sel_out, .single_shot_out,
  .low_latency_filter_out, .rate_csps_out, .rate_reserved_out,
  .neg_ref_buffer_bypass_out, .filter_restart_out, .delay_busy_out,
  .first_conv_start_out);

// ===== test/host_bus_model.sv
// Host controller model driving the register strobe port
module host_bus_model (
  input wire clk_in,
  output logic wr_en_out = 1'h0,
  output logic rd_en_out = 1'h0,
  output logic [7:0] addr_out = 8'hFF,
  output logic [7:0] wdata_out = 8'hFF
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines show the inverse, so stale values never look valid
  task automatic xfer(input bit wr, input logic [7:0] a, d);
    if (wr && a == 8'h03 && d[4:3] == 2'h0) d[2:0] = 3'h0;
    @(negedge clk_in);
    wr_en_out = wr;
    rd_en_out = !wr;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_en_out = 1'h0;
    rd_en_out = 1'h0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule // host_bus_model

// ===== test/tb_top.sv
// Self-checking bench for the gain, rate and reference config slice
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'h0, nrst_in = 1'h0, mod_tick_in = 1'h0;
  logic wr, rd, amp_on, amp_by, amp_rs, chop, extc, sshot, lowlat, rrs;
  logic pbuf, nbuf, rx0, rx1, rint, ron, rkeep, restart, busy, start;
  logic [7:0] ad, wd, rdata, gain, v;
  logic [1:0] mon;
  logic [16:0] csps;
  logic [16:0] q[$];
  int fails = 0, n_checks = 0, n;
  logic [16:0] rt[12] = '{17'h000FA, 17'h001F4, 17'h003E8, 17'h0067C,
    17'h007D0, 17'h01388, 17'h01770, 17'h02710, 17'h04E20, 17'h09C40,
    17'h13880, 17'h186A0};
  logic [11:0] dl[8] = '{12'h00E, 12'h019, 12'h040, 12'h100, 12'h400,
    12'h800, 12'h800, 12'h001};
  host_bus_model host_bus_model_inst (.clk_in(clk_in), .wr_en_out(wr),
    .rd_en_out(rd), .addr_out(ad), .wdata_out(wd));
  adc_gain_rate_ref_config adc_gain_rate_ref_config_inst (.clk_in(clk_in),
    .nrst_in(nrst_in), .wr_en_in(wr), .rd_en_in(rd), .addr_in(ad),
    .wdata_in(wd), .mod_tick_in(mod_tick_in), .rdata_out(rdata),
    .amp_enable_out(amp_on), .amp_bypass_out(amp_by),
    .amp_reserved_out(amp_rs), .gain_out(gain), .chop_enable_out(chop),
    .ext_clk_sel_out(extc), .single_shot_out(sshot),
    .low_latency_filter_out(lowlat), .rate_csps_out(csps),
    .rate_reserved_out(rrs), .ref_monitor_cfg_out(mon),
    .pos_ref_buffer_bypass_out(pbuf), .neg_ref_buffer_bypass_out(nbuf),
    .ref_ext0_out(rx0), .ref_ext1_out(rx1), .ref_internal_out(rint),
    .int_ref_on_out(ron), .int_ref_keep_in_pdown_out(rkeep),
    .filter_restart_out(restart), .delay_busy_out(busy),
    .first_conv_start_out(start));
  task automatic check(input string nm, input logic [23:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rd_reg(input logic [7:0] a, exp);
    q.push_back({9'h0, exp});
    host_bus_model_inst.xfer(1'b0, a, 8'h00);
  endtask
  initial forever #5 clk_in = ~clk_in;
  initial begin
    #300000;
    fails++;
    report_and_stop;
  end
  always @(posedge clk_in) begin
    if (rd === 1'h1) begin
      @(negedge clk_in);
      check("rdata", rdata, q.pop_front());
    end
  end
  initial begin
    void'($urandom(20024));
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'h1;
    check("rst_rate", {chop, extc, sshot, lowlat, csps}, 24'h0207D0);
    check("rst_amp", {amp_on, amp_by, gain}, 17'h101);
    check("rst_ref", {mon, pbuf, nbuf, rx0, ron}, 17'h6);
    rd_reg(8'h04, 8'h14);
    rd_reg(8'h05, 8'h10);
    rd_reg(8'h07, 8'h00);
    for (int c = 0; c < 16; c++) begin
      v = $urandom();
      v[3:0] = c[3:0];
      host_bus_model_inst.xfer(1'b1, 8'h04, v);
      @(negedge clk_in);
      check("csps", csps, c < 12 ? rt[c] : 17'h0);
      check("rbits", {chop, extc, sshot, lowlat, rrs},
        {v[7:4], c > 11});
      rd_reg(8'h04, v);
      v = $urandom();
      v[3:0] = c[3:0];
      host_bus_model_inst.xfer(1'b1, 8'h05, v);
      @(negedge clk_in);
      check("ref", {mon, pbuf, nbuf}, v[7:4]);
      check("sel", {rx0, rx1, rint},
        {c / 4 == 0, c / 4 == 1, c / 4 == 2});
      check("int", {ron, rkeep},
        {c % 4 == 1 || c % 4 == 2, c % 4 == 2});
      rd_reg(8'h05, v);
    end
    for (int a = 0; a < 32; a++) begin
      v = {3'h0, a[4:0]};
      host_bus_model_inst.xfer(1'b1, 8'h03, v);
      if (a < 8) v = 8'h00;
      @(negedge clk_in);
      check("gain", gain, 17'h1 << v[2:0]);
      check("amp", {amp_on, amp_by, amp_rs},
        {a / 8 == 1, a < 8, a > 15});
      rd_reg(8'h03, v);
    end
    for (int d = 0; d < 8; d++) begin
      host_bus_model_inst.xfer(1'b1, 8'h03, {d[2:0], 5'h08});
      check("restart", restart, 24'h1);
      n = 0;
      while (!start) begin
        @(negedge clk_in);
        mod_tick_in = busy & ~mod_tick_in;
        n += mod_tick_in;
      end
      check("ticks", n[16:0], {5'h0, dl[d]});
    end
    host_bus_model_inst.xfer(1'b1, 8'h03, 8'hE8);
    check("restart", restart, 24'h0);
    @(negedge clk_in);
    check("busy", busy, 17'h0);
    report_and_stop;
  end
endmodule // tb_top
